//--- inc/smd_pkg.sv
// Constants for the sync mode detector
package smd_pkg;
   localparam logic [7:0] SMD_ADDR_HFP = 8'h00_f6;
   localparam logic [7:0] SMD_ADDR_HFPW = 8'h00_f7;
   localparam logic [7:0] SMD_ADDR_CST = 8'h00_f8;
   localparam logic [7:0] SMD_ADDR_VFP = 8'h00_f9;
   localparam logic [7:0] SMD_ADDR_VFPW = 8'h00_fa;
   localparam logic [7:0] SMD_ADDR_PUL = 8'h00_fb;
   localparam logic [7:0] SMD_ADDR_HCNT = 8'h00_fc;
   localparam logic [7:0] SMD_ADDR_VCNT = 8'h00_fd;
   localparam logic [7:0] SMD_ADDR_LOWN = 8'h00_fe;
   localparam int SMD_BIT_EN = 7;
   localparam int SMD_BIT_CHG = 6;
   localparam int SMD_BIT_HALF = 5;
   localparam int SMD_BIT_HSEL = 4;
   localparam int SMD_BIT_HPRES = 3;
   localparam int SMD_BIT_VPRES = 2;
   localparam int SMD_BIT_HPOL = 1;
   localparam int SMD_BIT_VPOL = 0;
   localparam int SMD_BIT_VSEL = 7;
   localparam int SMD_BIT_WHITE = 0;
   localparam int SMD_BIT_HATCH = 1;
   localparam int SMD_BIT_FORCE = 2;
   localparam logic [7:0] SMD_CST_RST = 8'h00_80;
   localparam logic [7:0] SMD_RW_RST = 8'h00_00;
   localparam int SMD_CW = 12;
   localparam int SMD_HLINES = 4;
   localparam logic [SMD_CW-1:0] SMD_CMAX = 12'h0_fff;
   // Absence timeout in detect clock ticks
   localparam logic [15:0] SMD_ABSENT_TICKS = 16'hffff;
   // Free-run period scale: last divider count, one period unit is this plus one ticks
   localparam logic [3:0] SMD_FR_SCALE = 4'h0_f;
   localparam logic [3:0] SMD_HATCH_GRID = 4'h0_f;
endpackage

//--- logic/smd_edge_meas.sv
// One sync channel: polarity, presence and period count
`timescale 1ns/10ps
`default_nettype none
module smd_edge_meas (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic tick_in,
   input wire logic enable_in,
   input wire logic sync_in,
   input wire logic [2:0] edges_in,
   output logic present_out,
   output logic neg_pol_out,
   output logic meas_out,
   output logic [smd_pkg::SMD_CW-1:0] count_out
);
   import smd_pkg::*;

   logic prev_r;
   logic [15:0] hi_r;
   logic [15:0] lo_r;
   logic [15:0] idle_r;
   logic [SMD_CW-1:0] run_r;
   logic [2:0] edg_r;
   logic lead_edge;

   // Active edge is the start of the shorter phase
   assign lead_edge = neg_pol_out ? (prev_r & ~sync_in) : (~prev_r & sync_in);

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prev_r <= 1'b0;
         hi_r <= '0;
         lo_r <= '0;
      end else if (tick_in && enable_in) begin
         prev_r <= sync_in;
         // Phase counts restart each active edge
         if (lead_edge) begin
            hi_r <= '0;
            lo_r <= '0;
         end else begin
            if (sync_in && hi_r != 16'hffff) hi_r <= hi_r + 16'h0001;
            if (!sync_in && lo_r != 16'hffff) lo_r <= lo_r + 16'h0001;
         end
      end
   end

   // Polarity from duty: longer high phase means negative sync
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         neg_pol_out <= 1'b0;
      end else if (tick_in && enable_in && lead_edge && present_out) begin
         neg_pol_out <= (hi_r > lo_r);
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         idle_r <= '0;
         present_out <= 1'b0;
      end else if (tick_in && enable_in) begin
         if (prev_r != sync_in) begin
            idle_r <= '0;
            present_out <= 1'b1;
         end else if (idle_r == SMD_ABSENT_TICKS) begin
            present_out <= 1'b0;
         end else begin
            idle_r <= idle_r + 16'h0001;
         end
      end
   end

   // Period count over edges_in active edges
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         run_r <= '0;
         edg_r <= '0;
         count_out <= '0;
         meas_out <= 1'b0;
      end else begin
         meas_out <= 1'b0;
         if (tick_in && enable_in) begin
            if (run_r != SMD_CMAX) run_r <= run_r + 12'h0_001;
            if (lead_edge) begin
               if (edg_r + 3'd1 >= edges_in) begin
                  count_out <= run_r;
                  meas_out <= 1'b1;
                  // Edge tick opens the next window
                  run_r <= 12'h001;
                  edg_r <= '0;
               end else begin
                  edg_r <= edg_r + 3'd1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- logic/smd_top.sv
// Sync mode detector with free-run sync and test patterns
`timescale 1ns/10ps
`default_nettype none
module smd_top (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic idle_in,
   input wire logic hsync_pin_in,
   input wire logic vsync_pin_in,
   input wire logic csync_pin_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   output logic [7:0] sfr_rdata_out,
   output logic hsync_out,
   output logic vsync_out,
   output logic freerun_out,
   output logic video_out
);
   import smd_pkg::*;

   typedef enum logic [3:0] {
      SMD_ON = 4'b0001,
      SMD_STBY = 4'b0010,
      SMD_SUSP = 4'b0100,
      SMD_OFF = 4'b1000
   } smd_pwr_t;

   logic [1:0] hs_sync_r;
   logic [1:0] vs_sync_r;
   logic [1:0] cs_sync_r;
   logic [7:0] cst_r;
   logic [7:0] hfp_r;
   logic [7:0] hfpw_r;
   logic [7:0] vfp_r;
   logic [7:0] vfpw_r;
   logic [7:0] pul_r;
   logic half_r;
   logic tick;
   logic h_sel;
   logic v_sep_r;
   logic [7:0] csep_cnt_r;
   logic v_sel;
   logic h_pres;
   logic v_pres;
   logic h_neg;
   logic v_neg;
   logic h_meas;
   logic v_meas;
   logic [SMD_CW-1:0] h_cnt;
   logic [SMD_CW-1:0] v_cnt;
   logic [SMD_CW-1:0] h_last_r;
   logic [SMD_CW-1:0] v_last_r;
   logic [1:0] pol_last_r;
   logic chg_r;
   logic chg_set;
   logic det_en;
   smd_pwr_t pwr_r;
   logic [3:0] hdiv_r;
   logic [9:0] hcnt_fr_r;
   logic [9:0] vcnt_fr_r;
   logic [3:0] grid_r;
   logic fr_on;

   ////////////////////////////////////////////////////////////////
   function automatic logic [9:0] smd_period(input logic [7:0] hi, input logic [7:0] lo);
      smd_period = {hi, lo[6:5]};
   endfunction

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hs_sync_r <= '0;
         vs_sync_r <= '0;
         cs_sync_r <= '0;
      end else begin
         hs_sync_r <= {hs_sync_r[0], hsync_pin_in};
         vs_sync_r <= {vs_sync_r[0], vsync_pin_in};
         cs_sync_r <= {cs_sync_r[0], csync_pin_in};
      end
   end

   // Detect clock enable: every cycle or every other
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         half_r <= 1'b0;
      end else begin
         half_r <= ~half_r;
      end
   end
   assign tick = cst_r[SMD_BIT_HALF] ? half_r : 1'b1;

   // Idle input deliberately not used to gate anything
   assign det_en = cst_r[SMD_BIT_EN];
   assign h_sel = cst_r[SMD_BIT_HSEL] ? cs_sync_r[1] : hs_sync_r[1];

   // Vertical separated from composite: long low phase
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         csep_cnt_r <= '0;
         v_sep_r <= 1'b0;
      end else if (tick) begin
         if (cs_sync_r[1]) begin
            csep_cnt_r <= '0;
            v_sep_r <= 1'b0;
         end else if (csep_cnt_r != 8'h00_ff) begin
            csep_cnt_r <= csep_cnt_r + 8'h00_01;
         end else begin
            v_sep_r <= 1'b1;
         end
      end
   end
   assign v_sel = hfpw_r[SMD_BIT_VSEL] ? v_sep_r : vs_sync_r[1];

   smd_edge_meas u_hmeas (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .tick_in(tick),
      .enable_in(det_en),
      .sync_in(h_sel),
      .edges_in(3'(SMD_HLINES)),
      .present_out(h_pres),
      .neg_pol_out(h_neg),
      .meas_out(h_meas),
      .count_out(h_cnt)
   );

   smd_edge_meas u_vmeas (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .tick_in(tick),
      .enable_in(det_en),
      .sync_in(v_sel),
      .edges_in(3'd1),
      .present_out(v_pres),
      .neg_pol_out(v_neg),
      .meas_out(v_meas),
      .count_out(v_cnt)
   );

   ////////////////////////////////////////////////////////////////
   assign chg_set = (h_meas && h_cnt != h_last_r) || (v_meas && v_cnt != v_last_r)
      || ({h_neg, v_neg} != pol_last_r);

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         h_last_r <= '0;
         v_last_r <= '0;
         pol_last_r <= '0;
      end else begin
         if (h_meas) h_last_r <= h_cnt;
         if (v_meas) v_last_r <= v_cnt;
         pol_last_r <= {h_neg, v_neg};
      end
   end

   // Flag falls after a clean unchanged vertical measurement
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         chg_r <= 1'b0;
      end else if (chg_set) begin
         chg_r <= 1'b1;
      end else if (v_meas || (sfr_wr_in && sfr_addr_in == SMD_ADDR_CST
                              && !sfr_wdata_in[SMD_BIT_CHG])) begin
         chg_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cst_r <= SMD_CST_RST;
         hfp_r <= SMD_RW_RST;
         hfpw_r <= SMD_RW_RST;
         vfp_r <= SMD_RW_RST;
         vfpw_r <= SMD_RW_RST;
         pul_r <= SMD_RW_RST;
      end else if (sfr_wr_in) begin
         unique case (sfr_addr_in)
            SMD_ADDR_CST: cst_r <= {sfr_wdata_in[7], 1'b0, sfr_wdata_in[5:4], 4'h0};
            SMD_ADDR_HFP: hfp_r <= sfr_wdata_in;
            SMD_ADDR_HFPW: hfpw_r <= sfr_wdata_in;
            SMD_ADDR_VFP: vfp_r <= sfr_wdata_in;
            SMD_ADDR_VFPW: vfpw_r <= {2'b00, sfr_wdata_in[5:0]};
            SMD_ADDR_PUL: pul_r <= sfr_wdata_in;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sfr_rdata_out <= '0;
      end else if (sfr_rd_in) begin
         unique case (sfr_addr_in)
            SMD_ADDR_CST: sfr_rdata_out <= {cst_r[7], chg_r, cst_r[5:4],
                                             h_pres, v_pres, h_neg, v_neg};
            SMD_ADDR_HFP: sfr_rdata_out <= hfp_r;
            SMD_ADDR_HFPW: sfr_rdata_out <= hfpw_r;
            SMD_ADDR_VFP: sfr_rdata_out <= vfp_r;
            SMD_ADDR_VFPW: sfr_rdata_out <= vfpw_r;
            SMD_ADDR_PUL: sfr_rdata_out <= pul_r;
            SMD_ADDR_HCNT: sfr_rdata_out <= h_last_r[11:4];
            SMD_ADDR_VCNT: sfr_rdata_out <= v_last_r[11:4];
            SMD_ADDR_LOWN: sfr_rdata_out <= {v_last_r[3:0], h_last_r[3:0]};
            default: sfr_rdata_out <= 8'h00_00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Power state from sync presence
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pwr_r <= SMD_ON;
      end else begin
         unique case ({h_pres, v_pres})
            2'b11: pwr_r <= SMD_ON;
            2'b01: pwr_r <= SMD_STBY;
            2'b10: pwr_r <= SMD_SUSP;
            2'b00: pwr_r <= SMD_OFF;
         endcase
      end
   end
   assign fr_on = (pwr_r != SMD_ON) || pul_r[SMD_BIT_FORCE];

   // Free-running sync generators
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hdiv_r <= '0;
         hcnt_fr_r <= '0;
         vcnt_fr_r <= '0;
         grid_r <= '0;
      end else if (tick) begin
         hdiv_r <= (hdiv_r == SMD_FR_SCALE) ? 4'h0_0 : hdiv_r + 4'h0_1;
         if (hdiv_r == SMD_FR_SCALE) begin
            if (hcnt_fr_r + 10'h001 >= smd_period(hfp_r, hfpw_r)) begin
               hcnt_fr_r <= '0;
               vcnt_fr_r <= (vcnt_fr_r + 10'h001 >= smd_period(vfp_r, vfpw_r << 1)) ? 10'h000
                            : vcnt_fr_r + 10'h001;
            end else begin
               hcnt_fr_r <= hcnt_fr_r + 10'h001;
            end
            grid_r <= grid_r + 4'h0_1;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hsync_out <= 1'b0;
         vsync_out <= 1'b0;
         freerun_out <= 1'b0;
         video_out <= 1'b0;
      end else begin
         freerun_out <= fr_on;
         hsync_out <= fr_on ? (hcnt_fr_r < {5'h00, hfpw_r[4:0]}) : h_sel;
         vsync_out <= fr_on ? (vcnt_fr_r < {6'h00, vfpw_r[3:0]}) : v_sel;
         video_out <= fr_on && (pul_r[SMD_BIT_WHITE] ||
                      (pul_r[SMD_BIT_HATCH] && (hcnt_fr_r[3:0] == 4'h0_0 ||
                       vcnt_fr_r[3:0] == 4'h0_0)));
      end
   end

   ////////////////////////////////////////////////////////////////
   property p_en_reset;
      @(posedge mclk_in) $rose(nrst_in) |-> cst_r[SMD_BIT_EN];
   endproperty
   a_en_reset: assert property (p_en_reset) else $error("enable not set after reset");

   property p_chg_set;
      @(posedge mclk_in) disable iff (!nrst_in) chg_set |=> chg_r;
   endproperty
   a_chg_set: assert property (p_chg_set) else $error("change flag not raised");

   property p_chg_fall;
      @(posedge mclk_in) disable iff (!nrst_in) $fell(chg_r) |-> !$past(chg_set);
   endproperty
   a_chg_fall: assert property (p_chg_fall) else $error("flag fell during change");

   property p_tick_half;
      @(posedge mclk_in) disable iff (!nrst_in)
         cst_r[SMD_BIT_HALF] && $past(cst_r[SMD_BIT_HALF]) && $past(tick) |-> !tick;
   endproperty
   a_tick_half: assert property (p_tick_half) else $error("half clock ticks twice");

   property p_hsel;
      @(posedge mclk_in) disable iff (!nrst_in)
         cst_r[SMD_BIT_HSEL] |-> h_sel == cs_sync_r[1];
   endproperty
   a_hsel: assert property (p_hsel) else $error("composite not routed");

   property p_lown;
      @(posedge mclk_in) disable iff (!nrst_in)
         sfr_rd_in && sfr_addr_in == SMD_ADDR_LOWN |=> sfr_rdata_out[3:0] == $past(h_last_r[3:0]);
   endproperty
   a_lown: assert property (p_lown) else $error("low nibble wrong");

   property p_pwr;
      @(posedge mclk_in) disable iff (!nrst_in) !h_pres && !v_pres |=> ##1 freerun_out;
   endproperty
   a_pwr: assert property (p_pwr) else $error("no free run when off");

   property p_white;
      @(posedge mclk_in) disable iff (!nrst_in) fr_on && pul_r[SMD_BIT_WHITE] |=> video_out;
   endproperty
   a_white: assert property (p_white) else $error("white pattern missing");
endmodule
`default_nettype wire

//--- tb/smd_sync_src.sv
// Graphics source model driving horizontal, vertical and composite sync
`timescale 1ns/10ps
`default_nettype none
module smd_sync_src (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [7:0] h_per_in,
   input wire logic [7:0] c_per_in,
   input wire logic h_on_in,
   input wire logic v_on_in,
   input wire logic h_neg_in,
   input wire logic v_neg_in,
   output logic hsync_out,
   output logic vsync_out,
   output logic csync_out
);
   localparam logic [7:0] SRC_WIDTH = 8'h08;
   localparam logic [3:0] SRC_LINES = 4'h8;
   logic [7:0] hcnt_r;
   logic [7:0] ccnt_r;
   logic [3:0] line_r;
   ////////////////////////////////////////////////////////////////////////////////
   // Line and field counters
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hcnt_r <= 8'h00;
         line_r <= 4'h0;
      end else if (hcnt_r >= h_per_in - 8'h01) begin
         hcnt_r <= 8'h00;
         line_r <= (line_r == SRC_LINES - 4'h1) ? 4'h0 : line_r + 4'h1;
      end else begin
         hcnt_r <= hcnt_r + 8'h01;
      end
   end
   // Composite line counter
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ccnt_r <= 8'h00;
      end else begin
         ccnt_r <= (ccnt_r >= c_per_in - 8'h01) ? 8'h00 : ccnt_r + 8'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Pins; a stopped sync sits at its inactive level
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hsync_out <= 1'b0;
         vsync_out <= 1'b0;
         csync_out <= 1'b0;
      end else begin
         hsync_out <= h_on_in ? ((hcnt_r < SRC_WIDTH) ^ h_neg_in) : h_neg_in;
         vsync_out <= v_on_in ? ((line_r == 4'h0) ^ v_neg_in) : v_neg_in;
         csync_out <= ccnt_r < SRC_WIDTH;
      end
   end
endmodule
`default_nettype wire

//--- tb/sync_mode_detector_tb_top.sv
// Self-checking bench for the sync mode detector
`timescale 1ns/10ps
`default_nettype none
module sync_mode_detector_tb_top;
   import smd_pkg::*;
   typedef struct {string what; logic [7:0] exp; logic [7:0] mask;} smd_note_t;
   logic mclk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic idle_in = 1'b0;
   logic [7:0] sfr_addr_in = 8'h00;
   logic [7:0] sfr_wdata_in = 8'h00;
   logic sfr_wr_in = 1'b0;
   logic sfr_rd_in = 1'b0;
   logic [7:0] sfr_rdata_out;
   logic hsync_out, vsync_out, freerun_out, video_out;
   logic hs_w, vs_w, cs_w;
   logic [7:0] h_per = 8'h40;
   logic [7:0] c_per = 8'h32;
   logic h_on = 1'b0, v_on = 1'b0, h_neg = 1'b0, v_neg = 1'b0;
   logic rd_seen = 1'b0;
   logic [7:0] rdat, d;
   logic [7:0] rw_tbl [5] = '{SMD_ADDR_HFP, SMD_ADDR_HFPW, SMD_ADDR_VFP, SMD_ADDR_VFPW, SMD_ADDR_PUL};
   logic [7:0] ro_tbl [3] = '{SMD_ADDR_HCNT, SMD_ADDR_VCNT, SMD_ADDR_LOWN};
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int seed, h, n;
   smd_note_t notes[$];
   smd_note_t nt;
   smd_top i_smd_top (.mclk_in, .nrst_in, .idle_in, .hsync_pin_in(hs_w), .vsync_pin_in(vs_w),
      .csync_pin_in(cs_w), .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in,
      .sfr_rdata_out, .hsync_out, .vsync_out, .freerun_out, .video_out);
   smd_sync_src i_smd_sync_src (.mclk_in, .nrst_in, .h_per_in(h_per), .c_per_in(c_per),
      .h_on_in(h_on), .v_on_in(v_on), .h_neg_in(h_neg), .v_neg_in(v_neg),
      .hsync_out(hs_w), .vsync_out(vs_w), .csync_out(cs_w));
   initial begin
      forever #12.5 mclk_in = ~mclk_in;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Compare, report and bus tasks
   task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] s,
         input logic [7:0] m);
      tests_run++;
      if (((s ^ e) & m) !== 8'h00) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic cmp1(input string what, input logic e, input logic s);
      tests_run++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s expected %b seen %b", what, e, s);
      end
   endtask
   task automatic end_of_test();
      if (n_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk_in);
      sfr_addr_in <= a;
      sfr_wdata_in <= v;
      sfr_wr_in <= 1'b1;
      @(posedge mclk_in);
      sfr_wr_in <= 1'b0;
   endtask
   task automatic sfr_read(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
         input string what);
      @(posedge mclk_in);
      sfr_addr_in <= a;
      sfr_rd_in <= 1'b1;
      notes.push_back('{what, e, m});
      @(posedge mclk_in);
      sfr_rd_in <= 1'b0;
      @(posedge mclk_in);
      #1 rdat = sfr_rdata_out;
   endtask
   // Poll until the change flag has risen and fallen again
   task automatic wait_settle();
      int k;
      k = 0;
      do begin
         sfr_read(SMD_ADDR_CST, 8'h00, 8'h00, "poll");
         k++;
      end while (rdat[SMD_BIT_CHG] !== 1'b1 && k < 3000);
      cmp1("chg_raised", 1'b1, rdat[SMD_BIT_CHG]);
      do begin
         sfr_read(SMD_ADDR_CST, 8'h00, 8'h00, "poll");
         k++;
      end while (rdat[SMD_BIT_CHG] !== 1'b0 && k < 6000);
      cmp1("chg_fell", 1'b0, rdat[SMD_BIT_CHG]);
   endtask
   task automatic check_meas(input logic [7:0] st, input int hv, input int vv);
      logic [11:0] hc, vc;
      hc = (hv > 4095) ? SMD_CMAX : hv[11:0];
      vc = (vv > 4095) ? SMD_CMAX : vv[11:0];
      sfr_read(SMD_ADDR_CST, st, 8'hff, "status");
      sfr_read(SMD_ADDR_HCNT, hc[11:4], 8'hff, "h_count");
      sfr_read(SMD_ADDR_VCNT, vc[11:4], 8'hff, "v_count");
      sfr_read(SMD_ADDR_LOWN, {vc[3:0], hc[3:0]}, 8'hff, "low_nibbles");
   endtask
   // Cycles until the next rising edge of the horizontal output
   task automatic fr_rise(output int c);
      logic p;
      c = 0;
      p = 1'b1;
      while (!(p === 1'b0 && hsync_out === 1'b1) && c < 4000) begin
         p = hsync_out;
         @(posedge mclk_in);
         #1;
         c++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Result monitor and timeout
   always @(posedge mclk_in) rd_seen <= sfr_rd_in;
   always @(posedge mclk_in) begin
      if (rd_seen === 1'b1 && notes.size() > 0) begin
         #1;
         nt = notes.pop_front();
         cmp8(nt.what, nt.exp, sfr_rdata_out, nt.mask);
      end
   end
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 98000) begin
         n_errors++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 2;
      repeat (4) @(posedge mclk_in);
      nrst_in <= 1'b1;
      sfr_read(SMD_ADDR_CST, SMD_CST_RST, 8'hfc, "cst_reset");
      foreach (rw_tbl[i]) sfr_read(rw_tbl[i], SMD_RW_RST, 8'hff, "rw_reset");
      foreach (ro_tbl[i]) sfr_read(ro_tbl[i], 8'h00, 8'hff, "count_reset");
      foreach (rw_tbl[i]) begin
         d = 8'($random(seed));
         sfr_write(rw_tbl[i], d);
         sfr_read(rw_tbl[i], d, (i == 3) ? 8'h3f : 8'hff, "rw_back");
      end
      foreach (ro_tbl[i]) begin
         sfr_write(ro_tbl[i], 8'($random(seed)));
         sfr_read(ro_tbl[i], 8'h00, 8'hff, "ro_count");
      end
      d = 8'($random(seed)) % 8'hf0;
      sfr_read(d, 8'h00, 8'hff, "unmapped");
      sfr_write(SMD_ADDR_CST, 8'h0f);
      sfr_read(SMD_ADDR_CST, 8'h00, 8'hfc, "cst_off");
      sfr_write(SMD_ADDR_CST, SMD_CST_RST);
      sfr_write(SMD_ADDR_HFP, 8'h01);
      sfr_write(SMD_ADDR_HFPW, 8'h02);
      sfr_write(SMD_ADDR_VFP, 8'h00);
      sfr_write(SMD_ADDR_VFPW, 8'h21);
      sfr_write(SMD_ADDR_PUL, 8'h00);
      h = 40 + ($random(seed) & 30);
      h_per <= 8'(h);
      h_on <= 1'b1;
      v_on <= 1'b1;
      wait_settle();
      check_meas(8'h8c, 4 * h, 8 * h);
      cmp1("freerun_on", 1'b0, freerun_out);
      h_neg <= 1'b1;
      v_neg <= 1'b1;
      wait_settle();
      check_meas(8'h8f, 4 * h, 8 * h);
      idle_in <= 1'b1;
      sfr_write(SMD_ADDR_CST, 8'ha0);
      wait_settle();
      check_meas(8'haf, 2 * h, 4 * h);
      sfr_write(SMD_ADDR_CST, 8'h90);
      wait_settle();
      check_meas(8'h9d, 4 * 50, 8 * h);
      idle_in <= 1'b0;
      sfr_write(SMD_ADDR_CST, SMD_CST_RST);
      v_on <= 1'b0;
      repeat (66000) @(posedge mclk_in);
      sfr_read(SMD_ADDR_CST, 8'h88, 8'hbc, "v_absent");
      cmp1("freerun_v_absent", 1'b1, freerun_out);
      fr_rise(n);
      fr_rise(n);
      cmp8("fr_period", 8'd64, 8'(n), 8'hff);
      n = 0;
      while (vsync_out !== 1'b1 && n < 4000) begin
         @(posedge mclk_in);
         #1 n++;
      end
      cmp1("fr_vsync", 1'b1, vsync_out);
      sfr_write(SMD_ADDR_PUL, 8'h01);
      n = 0;
      while (video_out !== 1'b1 && n < 4000) begin
         @(posedge mclk_in);
         #1 n++;
      end
      cmp1("white", 1'b1, video_out);
      sfr_write(SMD_ADDR_PUL, 8'h02);
      n = 0;
      while (video_out !== 1'b0 && n < 4000) begin
         @(posedge mclk_in);
         #1 n++;
      end
      cmp1("hatch_dark", 1'b0, video_out);
      end_of_test();
   end
endmodule
`default_nettype wire
